// ===== src/mqc_dec.sv
// Purpose: Decoder end; parses escaped coefficients and checks mode restrictions
// Assumes: Table lookup answers the query combinationally in the check cycle
// Notes:   Every parsed coefficient is reported, with error flags alongside
`timescale 1ns/1ps
`default_nettype none
module mqc_dec (
  // Clock and reset
  input  wire logic                       core_clk_i,
  input  wire logic                       nrst_i,
  // Picture and block state
  input  wire logic                       mode_en_i,
  input  wire logic                       deblock_en_i,
  input  wire logic                       chroma_i,
  input  wire logic [mqc_pkg::STEP_W-1:0] luma_step_i,
  // Table lookup query
  output logic                            lut_query_o,
  output logic                            lut_last_o,
  output logic [mqc_pkg::RUN_W-1:0]       lut_run_o,
  output logic [mqc_pkg::LVL_W-1:0]       lut_level_o,
  input  wire logic                       lut_hit_i,
  // Coefficient result
  output logic                            coef_valid_o,
  output logic                            coef_last_o,
  output logic [mqc_pkg::RUN_W-1:0]       coef_run_o,
  output logic [mqc_pkg::LVL_W-1:0]       coef_level_o,
  output logic                            coef_wide_o,
  output logic [mqc_pkg::REC_W-1:0]       coef_rec_mag_o,
  output logic [mqc_pkg::STEP_W-1:0]      coef_step_o,
  // Error flags, valid with coef_valid_o
  output logic                            err_syntax_o,
  output logic                            err_table_o,
  output logic                            err_range_o,
  output logic                            err_wide_step_o,
  output logic                            err_wide_small_o,
  // Steps for other consumers
  output logic [mqc_pkg::STEP_W-1:0]      deblock_luma_step_o,
  output logic [mqc_pkg::STEP_W-1:0]      deblock_chroma_step_o,
  output logic [mqc_pkg::STEP_W-1:0]      general_step_o,
  // Link
  mqc_link_if.dec                         link
);
  import mqc_pkg::*;

  typedef enum logic [2:0] {
    DEC_FIX  = 3'b001,
    DEC_WIDE = 3'b010,
    DEC_CHK  = 3'b100
  } mqc_dec_state_e;

  mqc_dec_state_e     state_r, state_nxt;
  logic [FRAME_W-1:0] sh_r, sh_nxt;
  logic [5:0]         cnt_r, cnt_nxt;
  logic               last_r, last_nxt;
  logic [RUN_W-1:0]   run_r, run_nxt;
  logic [LVL_W-1:0]   lvl_r, lvl_nxt;
  logic               wide_r, wide_nxt;
  logic               synerr_r, synerr_nxt;

  logic               o_valid_r, o_valid_nxt;
  logic               o_last_r, o_last_nxt;
  logic [RUN_W-1:0]   o_run_r, o_run_nxt;
  logic [LVL_W-1:0]   o_lvl_r, o_lvl_nxt;
  logic               o_wide_r, o_wide_nxt;
  logic [REC_W-1:0]   o_rec_r, o_rec_nxt;
  logic [STEP_W-1:0]  o_step_r, o_step_nxt;
  logic               e_syn_r, e_syn_nxt;
  logic               e_tab_r, e_tab_nxt;
  logic               e_rng_r, e_rng_nxt;
  logic               e_wst_r, e_wst_nxt;
  logic               e_wsm_r, e_wsm_nxt;

  logic [STEP_W-1:0]  dbl_step_r, dbl_step_nxt;
  logic [STEP_W-1:0]  dbc_step_r, dbc_step_nxt;
  logic [STEP_W-1:0]  gen_step_r, gen_step_nxt;

  logic               take;
  logic [10:0]        wfield;
  logic [10:0]        wlevel;
  logic [STEP_W-1:0]  chroma_step;
  logic [STEP_W-1:0]  coef_step;
  logic [LVL_W-1:0]   mag;
  logic [REC_W-1:0]   reconstructed_magnitude;

  always_comb begin
    take        = link.valid && ((state_r == DEC_FIX) || (state_r == DEC_WIDE));
    sh_nxt      = take ? {sh_r[FRAME_W-2:0], link.bit_d} : sh_r;
    wfield      = sh_nxt[10:0];
    wlevel      = {wfield[5:0], wfield[10:6]};
    chroma_step = chroma_step_f(luma_step_i);
    coef_step   = (mode_en_i && chroma_i) ? chroma_step : luma_step_i;
    mag         = abs_f(lvl_r);
    reconstructed_magnitude         = recon_mag_f(coef_step, mag);
  end

  // Parser
  always_comb begin
    state_nxt  = state_r;
    cnt_nxt    = cnt_r;
    last_nxt   = last_r;
    run_nxt    = run_r;
    lvl_nxt    = lvl_r;
    wide_nxt   = wide_r;
    synerr_nxt = synerr_r;
    case (state_r)
      DEC_FIX: begin
        if (take) begin
          cnt_nxt = cnt_r + 6'h01;
          if (cnt_r == 6'(FIX_LEN - 1)) begin
            cnt_nxt    = 6'h00;
            last_nxt   = sh_nxt[14];
            run_nxt    = sh_nxt[13:8];
            lvl_nxt    = {{4{sh_nxt[7]}}, sh_nxt[7:0]};
            wide_nxt   = 1'b0;
            synerr_nxt = (sh_nxt[21:15] != ESC_CODE) || (sh_nxt[7:0] == LVL_ZERO);
            if ((sh_nxt[7:0] == WIDE_MARK) && mode_en_i) begin
              wide_nxt  = 1'b1;
              state_nxt = DEC_WIDE;
            end else begin
              if (sh_nxt[7:0] == WIDE_MARK) begin
                synerr_nxt = 1'b1;
              end
              state_nxt = DEC_CHK;
            end
          end
        end
      end
      DEC_WIDE: begin
        if (take) begin
          cnt_nxt = cnt_r + 6'h01;
          if (cnt_r == 6'(WIDE_LEN - 1)) begin
            cnt_nxt   = 6'h00;
            lvl_nxt   = {{1{wlevel[10]}}, wlevel};
            state_nxt = DEC_CHK;
          end
        end
      end
      DEC_CHK: begin
        state_nxt = DEC_FIX;
      end
      default: begin
        state_nxt = DEC_FIX;
        cnt_nxt   = 6'h00;
      end
    endcase
  end

  // Checks and results
  always_comb begin
    o_valid_nxt  = 1'b0;
    o_last_nxt   = o_last_r;
    o_run_nxt    = o_run_r;
    o_lvl_nxt    = o_lvl_r;
    o_wide_nxt   = o_wide_r;
    o_rec_nxt    = o_rec_r;
    o_step_nxt   = o_step_r;
    e_syn_nxt    = e_syn_r;
    e_tab_nxt    = e_tab_r;
    e_rng_nxt    = e_rng_r;
    e_wst_nxt    = e_wst_r;
    e_wsm_nxt    = e_wsm_r;
    dbl_step_nxt = luma_step_i;
    dbc_step_nxt = (mode_en_i && deblock_en_i) ? chroma_step : luma_step_i;
    gen_step_nxt = luma_step_i;
    if (state_r == DEC_CHK) begin
      o_valid_nxt = 1'b1;
      o_last_nxt  = last_r;
      o_run_nxt   = run_r;
      o_lvl_nxt   = lvl_r;
      o_wide_nxt  = wide_r;
      o_rec_nxt   = reconstructed_magnitude;
      o_step_nxt  = coef_step;
      e_syn_nxt   = synerr_r;
      e_tab_nxt   = lut_hit_i;
      e_rng_nxt   = mode_en_i && (reconstructed_magnitude >= REC_LIM);
      e_wst_nxt   = wide_r && (coef_step >= WIDE_STEP_LIM);
      e_wsm_nxt   = wide_r && (mag <= LVL_LIM);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      state_r    <= DEC_FIX;
      sh_r       <= '0;
      cnt_r      <= 6'h00;
      last_r     <= 1'b0;
      run_r      <= '0;
      lvl_r      <= '0;
      wide_r     <= 1'b0;
      synerr_r   <= 1'b0;
      o_valid_r  <= 1'b0;
      o_last_r   <= 1'b0;
      o_run_r    <= '0;
      o_lvl_r    <= '0;
      o_wide_r   <= 1'b0;
      o_rec_r    <= '0;
      o_step_r   <= '0;
      e_syn_r    <= 1'b0;
      e_tab_r    <= 1'b0;
      e_rng_r    <= 1'b0;
      e_wst_r    <= 1'b0;
      e_wsm_r    <= 1'b0;
      dbl_step_r <= '0;
      dbc_step_r <= '0;
      gen_step_r <= '0;
    end else begin
      state_r    <= state_nxt;
      sh_r       <= sh_nxt;
      cnt_r      <= cnt_nxt;
      last_r     <= last_nxt;
      run_r      <= run_nxt;
      lvl_r      <= lvl_nxt;
      wide_r     <= wide_nxt;
      synerr_r   <= synerr_nxt;
      o_valid_r  <= o_valid_nxt;
      o_last_r   <= o_last_nxt;
      o_run_r    <= o_run_nxt;
      o_lvl_r    <= o_lvl_nxt;
      o_wide_r   <= o_wide_nxt;
      o_rec_r    <= o_rec_nxt;
      o_step_r   <= o_step_nxt;
      e_syn_r    <= e_syn_nxt;
      e_tab_r    <= e_tab_nxt;
      e_rng_r    <= e_rng_nxt;
      e_wst_r    <= e_wst_nxt;
      e_wsm_r    <= e_wsm_nxt;
      dbl_step_r <= dbl_step_nxt;
      dbc_step_r <= dbc_step_nxt;
      gen_step_r <= gen_step_nxt;
    end
  end

  // Link accepts while collecting bits
  assign link.ready            = (state_r == DEC_FIX) || (state_r == DEC_WIDE);
  assign lut_query_o           = (state_r == DEC_CHK);
  assign lut_last_o            = last_r;
  assign lut_run_o             = run_r;
  assign lut_level_o           = lvl_r;
  assign coef_valid_o          = o_valid_r;
  assign coef_last_o           = o_last_r;
  assign coef_run_o            = o_run_r;
  assign coef_level_o          = o_lvl_r;
  assign coef_wide_o           = o_wide_r;
  assign coef_rec_mag_o        = o_rec_r;
  assign coef_step_o           = o_step_r;
  assign err_syntax_o          = e_syn_r;
  assign err_table_o           = e_tab_r;
  assign err_range_o           = e_rng_r;
  assign err_wide_step_o       = e_wst_r;
  assign err_wide_small_o      = e_wsm_r;
  assign deblock_luma_step_o   = dbl_step_r;
  assign deblock_chroma_step_o = dbc_step_r;
  assign general_step_o        = gen_step_r;

endmodule : mqc_dec
`default_nettype wire

// ===== src/mqc_pkg.sv
// Purpose: Shared constants and helpers for the modified quantization coefficient codec
// Assumes: One clock at 200 MHz; link is one bit per accepted cycle, MSB first
// Notes:   Only escape-coded coefficients travel the link; table codewords are external
// Function
// - Mode acts only when picture field enables it
// - Chroma dequantised with chroma step when enabled
// - Chroma step derived from luma by table
// - Deblocking uses chroma step for chroma samples
// - All other quantizer uses take luma step
// - Level 1000 0000 after escape means wide
// - Magnitude above 127 sent as wide escape
// - Wide field is level rotated right five
// - Reconstructed magnitude must stay below 4096
// - Escapes must not encode table codeword combinations
// - Wide escape only when step below eight
// - Wide level must lie outside plus/minus 127
package mqc_pkg;

  localparam int         STEP_W      = 5;
  localparam int         RUN_W       = 6;
  localparam int         LVL_W       = 12;
  localparam int         REC_W       = 17;
  localparam int         FIX_LEN     = 22;
  localparam int         WIDE_LEN    = 11;
  localparam int         FRAME_W     = 33;
  localparam logic [6:0] ESC_CODE    = 7'h03;
  localparam logic [7:0] WIDE_MARK   = 8'h80;
  localparam logic [7:0] LVL_ZERO    = 8'h00;
  localparam int         ROT_RIGHT   = 5;
  localparam logic [LVL_W-1:0] LVL_LIM = 12'h07F;
  localparam logic [REC_W-1:0] REC_LIM = 17'h01000;
  localparam logic [STEP_W-1:0] WIDE_STEP_LIM = 5'h08;

  // Chroma step from luma step
  function automatic logic [STEP_W-1:0] chroma_step_f(input logic [STEP_W-1:0] q);
    logic [STEP_W-1:0] c;
    c = q;
    if (q <= 5'h06) begin
      c = q;
    end else if (q <= 5'h09) begin
      c = q - 5'h01;
    end else if (q <= 5'h0B) begin
      c = 5'h09;
    end else if (q <= 5'h0D) begin
      c = 5'h0A;
    end else if (q <= 5'h0F) begin
      c = 5'h0B;
    end else if (q <= 5'h12) begin
      c = 5'h0C;
    end else if (q <= 5'h15) begin
      c = 5'h0D;
    end else if (q <= 5'h1A) begin
      c = 5'h0E;
    end else begin
      c = 5'h0F;
    end
    return c;
  endfunction : chroma_step_f

  // Magnitude of a level
  function automatic logic [LVL_W-1:0] abs_f(input logic signed [LVL_W-1:0] l);
    logic [LVL_W-1:0] a;
    a = l[LVL_W-1] ? LVL_W'(-l) : LVL_W'(l);
    return a;
  endfunction : abs_f

  // Reconstruction magnitude: odd step q(2|L|+1), even step one less
  function automatic logic [REC_W-1:0] recon_mag_f(input logic [STEP_W-1:0] q,
                                                   input logic [LVL_W-1:0] a);
    logic [REC_W-1:0] r;
    r = REC_W'(q) * REC_W'({a, 1'b1});
    if (a == 12'h000) begin
      r = 17'h00000;
    end else if (!q[0]) begin
      r = r - 17'h00001;
    end
    return r;
  endfunction : recon_mag_f

endpackage : mqc_pkg

// ===== src/mqc_link_if.sv
// Purpose: Serial coded bitstream link between encoder end and decoder end
// Assumes: Both ends on the same clock
// Notes:   A bit moves on each cycle with valid and ready both high
`timescale 1ns/1ps
`default_nettype none
interface mqc_link_if;
  logic bit_d;
  logic valid;
  logic ready;

  modport enc (output bit_d, output valid, input ready);
  modport dec (input bit_d, input valid, output ready);
endinterface : mqc_link_if
`default_nettype wire

// ===== src/mqc_enc.sv
// Purpose: Encoder end; packs escaped coefficients onto the serial link
// Assumes: Caller supplies table-hit result for the offered last/run/level
// Notes:   Illegal coefficients are refused with a pulse and nothing is sent
`timescale 1ns/1ps
`default_nettype none
module mqc_enc (
  // Clock and reset
  input  wire logic                       core_clk_i,
  input  wire logic                       nrst_i,
  // Coefficient request
  input  wire logic                       req_valid_i,
  output logic                            req_ready_o,
  input  wire logic                       req_last_i,
  input  wire logic [mqc_pkg::RUN_W-1:0]  req_run_i,
  input  wire logic [mqc_pkg::LVL_W-1:0]  req_level_i,
  input  wire logic                       req_chroma_i,
  input  wire logic                       req_in_table_i,
  // Picture state
  input  wire logic                       mode_en_i,
  input  wire logic [mqc_pkg::STEP_W-1:0] luma_step_i,
  // Status
  output logic                            done_o,
  output logic                            refuse_o,
  // Link
  mqc_link_if.enc                         link
);
  import mqc_pkg::*;

  typedef enum logic [1:0] {
    ENC_IDLE = 2'b01,
    ENC_SEND = 2'b10
  } mqc_enc_state_e;

  mqc_enc_state_e       state_r, state_nxt;
  logic [FRAME_W-1:0]   sh_r, sh_nxt;
  logic [5:0]           len_r, len_nxt;
  logic                 done_r, done_nxt;
  logic                 refuse_r, refuse_nxt;

  logic [STEP_W-1:0]    step;
  logic [LVL_W-1:0]     mag;
  logic                 wide;
  logic                 bad;
  logic [10:0]          rot;

  always_comb begin
    step = (mode_en_i && req_chroma_i) ? chroma_step_f(luma_step_i) : luma_step_i;
    mag  = abs_f(req_level_i);
    wide = mag > LVL_LIM;
    rot  = {req_level_i[ROT_RIGHT-1:0], req_level_i[10:ROT_RIGHT]};
    bad  = (mag == 12'h000) || req_in_table_i;
    if (wide && !mode_en_i) begin
      bad = 1'b1;
    end
    if (wide && (step >= WIDE_STEP_LIM)) begin
      bad = 1'b1;
    end
    if (mode_en_i && (recon_mag_f(step, mag) >= REC_LIM)) begin
      bad = 1'b1;
    end
    if (mag > 12'h400) begin
      bad = 1'b1;
    end
  end

  always_comb begin
    state_nxt  = state_r;
    sh_nxt     = sh_r;
    len_nxt    = len_r;
    done_nxt   = 1'b0;
    refuse_nxt = 1'b0;
    case (state_r)
      ENC_IDLE: begin
        if (req_valid_i) begin
          if (bad) begin
            refuse_nxt = 1'b1;
          end else if (wide) begin
            sh_nxt    = {ESC_CODE, req_last_i, req_run_i, WIDE_MARK, rot};
            len_nxt   = 6'(FIX_LEN + WIDE_LEN);
            state_nxt = ENC_SEND;
          end else begin
            sh_nxt    = {ESC_CODE, req_last_i, req_run_i, req_level_i[7:0], 11'h000};
            len_nxt   = 6'(FIX_LEN);
            state_nxt = ENC_SEND;
          end
        end
      end
      ENC_SEND: begin
        if (link.ready) begin
          sh_nxt  = {sh_r[FRAME_W-2:0], 1'b0};
          len_nxt = len_r - 6'h01;
          if (len_r == 6'h01) begin
            done_nxt  = 1'b1;
            state_nxt = ENC_IDLE;
          end
        end
      end
      default: begin
        state_nxt = ENC_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      state_r  <= ENC_IDLE;
      sh_r     <= '0;
      len_r    <= 6'h00;
      done_r   <= 1'b0;
      refuse_r <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      sh_r     <= sh_nxt;
      len_r    <= len_nxt;
      done_r   <= done_nxt;
      refuse_r <= refuse_nxt;
    end
  end

  assign req_ready_o = (state_r == ENC_IDLE);
  assign done_o      = done_r;
  assign refuse_o    = refuse_r;
  assign link.bit_d  = sh_r[FRAME_W-1];
  assign link.valid  = (state_r == ENC_SEND);

endmodule : mqc_enc
`default_nettype wire

// ===== tb/mqc_chk.sv
// Purpose: Link checker for the coefficient codec ends
// Assumes: One clock, synchronous active-low reset
// Notes:   Sees only the serial link signals
`timescale 1ns/1ps
`default_nettype none
module mqc_chk (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // Link
  input wire logic bit_d,
  input wire logic valid,
  input wire logic ready
);
  import mqc_pkg::*;

  logic        [5:0]  cnt_r;
  logic        [5:0]  cnt_nxt;
  logic        [32:0] sh_r;
  logic        [32:0] sh_nxt;
  logic signed [10:0] wl;

  always_comb begin
    cnt_nxt = valid ? cnt_r + 6'(valid & ready) : 6'h00;
    sh_nxt  = (valid & ready) ? {sh_r[31:0], bit_d} : sh_r;
  end

  always_ff @(posedge core_clk_i) begin
    cnt_r <= nrst_i ? cnt_nxt : 6'h00;
    sh_r  <= nrst_i ? sh_nxt : '0;
  end

  // Wide field rotated back left by five
  assign wl = {sh_r[5:0], sh_r[10:6]};

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);

  esc_prefix_a: assert property (valid && ready && cnt_r < 6'h07 |->
    bit_d == ESC_CODE[3'(6 - cnt_r)]) else $error("escape prefix bit wrong");
  frame_len_a: assert property ($fell(valid) |-> cnt_r == 6'h16 || cnt_r == 6'h21)
    else $error("frame length wrong");
  bit_cap_a: assert property (cnt_r <= 6'h21) else $error("frame too long");
  wide_mark_a: assert property ($fell(valid) && cnt_r == 6'h21 |->
    sh_r[18:11] == WIDE_MARK) else $error("wide mark missing");
  short_level_a: assert property ($fell(valid) && cnt_r == 6'h16 |->
    sh_r[7:0] != WIDE_MARK && sh_r[7:0] != LVL_ZERO) else $error("short level illegal");
  wide_range_a: assert property ($fell(valid) && cnt_r == 6'h21 |->
    wl > 11'sh07F || wl < -11'sh07F) else $error("wide level in short range");
  check_gap_a: assert property ($fell(valid) |-> !ready ##1 ready)
    else $error("parser gap wrong");
  frame_hold_a: assert property ($rose(valid) |-> valid [*8])
    else $error("frame broken early");

  cover property ($fell(valid) && cnt_r == 6'h16);
  cover property ($fell(valid) && cnt_r == 6'h21);
  cover property ($fell(valid) ##1 valid);
endmodule : mqc_chk
`default_nettype wire

// ===== tb/testbench.sv
// Purpose: Self-checking bench joining encoder and decoder ends
// Assumes: 200 MHz clock, synchronous active-low reset
// Notes:   Driver queues expectations, monitor pops on each result
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import mqc_pkg::*;

  typedef struct packed {
    logic        refused;
    logic        last;
    logic [5:0]  run;
    logic [11:0] lvl;
    logic        wide;
    logic [16:0] reconstructed_magnitude;
    logic [4:0]  step;
    logic [4:0]  errs;
  } mqc_exp_s;

  logic        core_clk_i;
  logic        nrst_i;
  logic        req_valid, req_last, req_chroma, req_tab, enc_mode;
  logic        dec_mode, dec_dbk, dec_chroma, dec_hit;
  logic [5:0]  req_run;
  logic [11:0] req_level;
  logic [4:0]  enc_step, dec_step;
  wire         req_ready, done, refused_p, cv, c_last, c_wide;
  wire  [5:0]  c_run;
  wire  [11:0] c_lvl;
  wire  [16:0] c_rec;
  wire  [4:0]  c_step, s_dl, s_dc, s_gen, c_err;
  wire         l_query, l_last;
  wire  [5:0]  l_run;
  wire  [11:0] l_lvl;
  mqc_exp_s    expq[$];
  mqc_exp_s    ce;
  integer      seed, err_total, n_checks, cycles;
  logic [19:0] dir_t [15] = '{20'h823FF, 20'h82C00, 20'h82C01, 20'hC90C8, 20'hC80C8,
    20'h81C00, 20'h81401, 20'h81F80, 20'h01080, 20'h0107F, 20'hA1005, 20'h81000,
    20'h9F07F, 20'h1F07F, 20'h87ED4};

  mqc_link_if mqc_link_if_inst ();
  mqc_enc mqc_enc_inst (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .req_valid_i(req_valid),
    .req_ready_o(req_ready), .req_last_i(req_last), .req_run_i(req_run),
    .req_level_i(req_level), .req_chroma_i(req_chroma), .req_in_table_i(req_tab),
    .mode_en_i(enc_mode), .luma_step_i(enc_step), .done_o(done), .refuse_o(refused_p),
    .link(mqc_link_if_inst));
  mqc_dec mqc_dec_inst (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .mode_en_i(dec_mode),
    .deblock_en_i(dec_dbk), .chroma_i(dec_chroma), .luma_step_i(dec_step),
    .lut_query_o(l_query), .lut_last_o(l_last), .lut_run_o(l_run), .lut_level_o(l_lvl),
    .lut_hit_i(dec_hit),
    .coef_valid_o(cv), .coef_last_o(c_last), .coef_run_o(c_run), .coef_level_o(c_lvl),
    .coef_wide_o(c_wide), .coef_rec_mag_o(c_rec), .coef_step_o(c_step),
    .err_syntax_o(c_err[4]), .err_table_o(c_err[3]), .err_range_o(c_err[2]),
    .err_wide_step_o(c_err[1]), .err_wide_small_o(c_err[0]),
    .deblock_luma_step_o(s_dl), .deblock_chroma_step_o(s_dc), .general_step_o(s_gen),
    .link(mqc_link_if_inst));
  mqc_chk mqc_chk_inst (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
    .bit_d(mqc_link_if_inst.bit_d), .valid(mqc_link_if_inst.valid),
    .ready(mqc_link_if_inst.ready));

  initial begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end

  function automatic logic [4:0] cstep(input logic [4:0] q);
    if (q <= 5'h06) return q;
    if (q <= 5'h09) return q - 5'h01;
    if (q <= 5'h0B) return 5'h09;
    if (q <= 5'h0D) return 5'h0A;
    if (q <= 5'h0F) return 5'h0B;
    if (q <= 5'h12) return 5'h0C;
    if (q <= 5'h15) return 5'h0D;
    if (q <= 5'h1A) return 5'h0E;
    return 5'h0F;
  endfunction : cstep

  function automatic logic [16:0] recf(input logic [4:0] q, input logic [11:0] a);
    logic [16:0] r;
    r = 17'(q) * (17'(a) * 17'h00002 + 17'h00001) - 17'(!q[0]);
    return (a == 12'h000) ? 17'h00000 : r;
  endfunction : recf

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] gt);
    n_checks++;
    if (ex !== gt) begin
      err_total++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, gt);
    end
  endtask : chk

  task automatic complete_run;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run

  task automatic cfg(input logic m, input logic c, input logic [4:0] s, input logic t);
    enc_mode = m;
    dec_mode = m;
    req_chroma = c;
    dec_chroma = c;
    enc_step = s;
    dec_step = s;
    req_tab = t;
    dec_hit = 1'b0;
  endtask : cfg

  // Hold keeps the next request in the done cycle
  task automatic send(input logic [11:0] lv, input logic [5:0] rn, input logic lt,
                      input logic hold);
    mqc_exp_s    e;
    logic [11:0] a;
    logic [4:0]  es, ds;
    int          wt;
    a  = lv[11] ? 12'(-lv) : lv;
    es = (enc_mode && req_chroma) ? cstep(enc_step) : enc_step;
    ds = (dec_mode && dec_chroma) ? cstep(dec_step) : dec_step;
    e.refused = a == 12'h000 || req_tab || (!enc_mode && a > 12'h07F) || a > 12'h400 ||
      (a > 12'h07F && es >= 5'h08) || (enc_mode && recf(es, a) >= 17'h01000);
    e.last = lt;
    e.run  = rn;
    e.lvl  = lv;
    e.wide = a > 12'h07F;
    e.reconstructed_magnitude  = recf(ds, a);
    e.step = ds;
    e.errs = {1'b0, dec_hit, dec_mode && e.reconstructed_magnitude >= 17'h01000, e.wide && ds >= 5'h08, 1'b0};
    expq.push_back(e);
    chk("req_ready", 32'h1, 32'(req_ready));
    req_level = lv;
    req_run = rn;
    req_last = lt;
    req_valid = 1'b1;
    @(posedge core_clk_i);
    #1;
    req_valid = 1'b0;
    wt = 0;
    while (!(done === 1'b1 || refused_p === 1'b1) && wt < 100) begin
      @(posedge core_clk_i);
      #1;
      wt++;
    end
    chk("done", 32'(!e.refused), 32'(done));
    chk("frame_cycles", e.refused ? 32'h0 : e.wide ? 32'(FIX_LEN + WIDE_LEN) : 32'(FIX_LEN),
        32'(wt));
    if (!hold) begin
      @(posedge core_clk_i);
      #1;
    end
  endtask : send

  always @(posedge core_clk_i) begin
    // Query fields belong to the oldest pending coefficient
    if (nrst_i && l_query === 1'b1) begin
      chk("lut_fields", 32'({expq[0].last, expq[0].run, expq[0].lvl}),
          32'({l_last, l_run, l_lvl}));
    end
    if (nrst_i && (cv === 1'b1 || refused_p === 1'b1)) begin
      if (expq.size() == 0) begin
        chk("unexpected", 32'h0, 32'h1);
      end else begin
        ce = expq.pop_front();
        chk("refuse", 32'(ce.refused), 32'(refused_p));
        if (!ce.refused) begin
          chk("level", 32'(ce.lvl), 32'(c_lvl));
          chk("wide", 32'(ce.wide), 32'(c_wide));
          chk("run_last", 32'({ce.run, ce.last}), 32'({c_run, c_last}));
          chk("rec_mag", 32'(ce.reconstructed_magnitude), 32'(c_rec));
          chk("coef_step", 32'(ce.step), 32'(c_step));
          chk("errors", 32'(ce.errs), 32'(c_err));
        end
      end
    end
  end

  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      complete_run();
    end
  end

  initial begin
    logic [11:0] lv;
    seed = 32'h6F24;
    err_total = 0;
    n_checks = 0;
    cycles = 0;
    nrst_i = 1'b0;
    req_valid = 1'b0;
    req_level = 12'h000;
    req_run = 6'h00;
    req_last = 1'b0;
    dec_dbk = 1'b0;
    cfg(1'b0, 1'b0, 5'h04, 1'b0);
    repeat (16) @(posedge core_clk_i);
    #1;
    nrst_i = 1'b1;
    for (int s = 1; s < 32; s++) begin
      for (int k = 0; k < 4; k++) begin
        dec_step = 5'(s);
        dec_mode = k[0];
        dec_dbk = k[1];
        @(posedge core_clk_i);
        #1;
        chk("dbk_luma", 32'(dec_step), 32'(s_dl));
        chk("general", 32'(dec_step), 32'(s_gen));
        chk("dbk_chroma", 32'(k == 3 ? cstep(dec_step) : dec_step), 32'(s_dc));
      end
    end
    for (int i = 0; i < 15; i++) begin
      cfg(dir_t[i][19], dir_t[i][18], dir_t[i][16:12], dir_t[i][17]);
      send(dir_t[i][11:0], 6'(i), i[0], 1'b0);
    end
    for (int k = 0; k < 4; k++) begin
      cfg(1'b1, 1'b0, 5'h04, 1'b0);
      dec_hit = (k == 0);
      dec_chroma = (k == 2);
      dec_step = (k == 1) ? 5'h0C : (k == 2) ? 5'h09 : (k == 3) ? 5'h1F : 5'h04;
      send((k == 3) ? 12'h07F : 12'h0C8, 6'h3F, 1'b1, 1'b0);
    end
    cfg(1'b1, 1'b0, 5'h03, 1'b0);
    for (int i = 0; i < 6; i++) begin
      lv = 12'($random(seed) % 600);
      send((lv == 12'h000) ? 12'h001 : lv, 6'($random(seed)), 1'b0, i < 5);
    end
    for (int i = 0; i < 40; i++) begin
      cfg(1'($random(seed)), 1'($random(seed)), 5'(1 + {$random(seed)} % 31),
          ($random(seed) & 7) == 0);
      dec_dbk = 1'($random(seed));
      lv = 12'($random(seed) % 1100);
      send((lv == 12'h400) ? 12'h3FF : lv, 6'($random(seed)), 1'($random(seed)),
           1'b0);
    end
    repeat (4) @(posedge core_clk_i);
    chk("pending", 32'h0, 32'(expq.size()));
    complete_run();
  end
endmodule : testbench
`default_nettype wire
